/* File: hw/phy_irq_pkg.sv */
// Purpose: shared constants and carriers of the phy interrupt logic
// Assumes: 5-bit management register address, 16-bit register data
// Notes: one source of truth for offsets, bit positions and reset values
`default_nettype none

package phy_irq_pkg;

   // ==========================================================
   // widths
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam int SRC_N = 8;

   // ==========================================================
   // register offsets
   localparam logic [ADDR_W-1:0] INTERRUPT_CONTROL_OFFS = 5'h11;
   localparam logic [ADDR_W-1:0] INTERRUPT_MASK_AND_STATUS_OFFS = 5'h12;

   // ==========================================================
   // field positions
   localparam int PIN_OUTPUT_SELECT_BIT = 0;
   localparam int IRQ_OUTPUT_ENABLE_BIT = 1;
   localparam int MASK_LSB = 0;
   localparam int FLAG_LSB = 8;
   localparam int ENERGY_DETECT_SRC = 5;
   localparam int LINK_CHANGE_SRC = 6;

   // ==========================================================
   // reset values and fixed read values
   localparam logic [1:0] CONTROL_RESET = 2'h0;
   localparam logic [SRC_N-1:0] MASK_RESET = 8'h00;
   localparam logic [SRC_N-1:0] FLAGS_RESET = 8'h00;
   localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

   typedef struct packed {
      logic in;
      logic out;
      logic oe;
   } pin_s;

endpackage

`default_nettype wire

/* File: hw/phy_interrupt_logic.sv */
// Purpose: interrupt logic of a 10/100 ethernet phy with a shared power-down/irq pin
// Assumes: single clock core_clk at 200 MHz, all inputs synchronous to it
// Notes: the pin asserts combinationally from the source inputs, not from a flop
//
// Contract
// - after reset every interrupt source is disabled and the pin is not driven.
// - bit 1 of interrupt_control at 0x11 gates whether any interrupt reaches the pin.
// - the low byte of interrupt_mask_and_status at 0x12 is a per-source mask.
// - an enabled unmasked condition drives the pin low without waiting for a clock edge.
// - the high byte of interrupt_mask_and_status flags which sources raised the interrupt.
// - several sources pending together all set their flags in the same cycle.
// - a read of interrupt_mask_and_status clears at once every pending flag whose source is not active in the read cycle.
// - once the flags are cleared the pin is released back to its high level.
// - writing 0060h to 0x12 sets the energy-detect and link-change mask bits.
// - bit 0 of interrupt_control turns the pin into an active-low interrupt output.
// - with bit 0 clear the pin is a power-down input and is never driven; the irq output still follows the pending flags.
`default_nettype none

module phy_interrupt_logic (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire phy_irq_pkg::reg_req_s reg_req,
   output logic [phy_irq_pkg::DATA_W-1:0] reg_rdata,
   input wire logic [phy_irq_pkg::SRC_N-1:0] irq_src,
   input wire logic powerdown_irq_pin_in,
   output logic powerdown_irq_pin_out,
   output logic powerdown_irq_pin_oe,
   output logic power_down,
   output logic irq
);
   import phy_irq_pkg::*;

   // ==========================================================
   // address decode
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] offs);
      hit = (a == offs);
   endfunction

   logic ctl_wr;
   logic stat_wr;
   logic stat_rd;
   logic ctl_rd;

   assign ctl_wr = clk_en && reg_req.wr && hit(reg_req.addr, INTERRUPT_CONTROL_OFFS);
   assign stat_wr = clk_en && reg_req.wr && hit(reg_req.addr, INTERRUPT_MASK_AND_STATUS_OFFS);
   assign ctl_rd = clk_en && reg_req.rd && hit(reg_req.addr, INTERRUPT_CONTROL_OFFS);
   assign stat_rd = clk_en && reg_req.rd && hit(reg_req.addr, INTERRUPT_MASK_AND_STATUS_OFFS);

   // ==========================================================
   // interrupt_control
   logic pin_output_select;
   logic irq_output_enable;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_output_select <= CONTROL_RESET[PIN_OUTPUT_SELECT_BIT];
         irq_output_enable <= CONTROL_RESET[IRQ_OUTPUT_ENABLE_BIT];
      end else if (ctl_wr) begin
         pin_output_select <= reg_req.wdata[PIN_OUTPUT_SELECT_BIT];
         irq_output_enable <= reg_req.wdata[IRQ_OUTPUT_ENABLE_BIT];
      end
   end

   // ==========================================================
   // mask, low byte of interrupt_mask_and_status
   logic [SRC_N-1:0] src_mask;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         src_mask <= MASK_RESET;
      end else if (stat_wr) begin
         src_mask <= reg_req.wdata[MASK_LSB +: SRC_N];
      end
   end

   // ==========================================================
   // pending flags, high byte; only the high byte is cleared by the read
   logic [SRC_N-1:0] pend;
   logic [SRC_N-1:0] hit_src;

   assign hit_src = irq_src & src_mask;

   generate
      for (genvar i = 0; i < SRC_N; i++) begin : g_flag
         always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
               pend[i] <= FLAGS_RESET[i];
            end else if (clk_en) begin
               // set beats the clearing read so no event is lost
               if (hit_src[i]) begin
                  pend[i] <= 1'b1;
               end else if (stat_rd) begin
                  pend[i] <= 1'b0;
               end
            end
         end

         masked_bit_a: assert property (
            @(posedge core_clk) disable iff (!rst_b)
            !pend[i] && !hit_src[i] |=> !pend[i])
            else $error("flag set with its source masked or idle");

         set_bit_a: assert property (
            @(posedge core_clk) disable iff (!rst_b)
            clk_en && hit_src[i] |=> pend[i])
            else $error("unmasked event did not set its flag");
      end
   endgenerate

   // ==========================================================
   // read port: data stand only in the cycle after the strobe
   logic [DATA_W-1:0] next_rdata;

   always_comb begin
      next_rdata = READ_ZERO;
      if (ctl_rd) begin
         next_rdata[PIN_OUTPUT_SELECT_BIT] = pin_output_select;
         next_rdata[IRQ_OUTPUT_ENABLE_BIT] = irq_output_enable;
      end else if (stat_rd) begin
         next_rdata[MASK_LSB +: SRC_N] = src_mask;
         next_rdata[FLAG_LSB +: SRC_N] = pend;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= READ_ZERO;
      end else if (clk_en) begin
         reg_rdata <= next_rdata;
      end
   end

   // ==========================================================
   // shared pin
   // the live source term makes assertion asynchronous to core_clk;
   // the flag keeps it low until the clearing read
   logic [SRC_N-1:0] live_pend;
   logic irq_cond;
   logic pin_drive;

   // a flag whose mask bit is cleared later stops driving the pin
   assign live_pend = pend & src_mask;
   assign irq_cond = (|live_pend) || (|hit_src);
   assign pin_drive = pin_output_select && irq_output_enable && irq_cond;

   assign powerdown_irq_pin_oe = pin_drive;
   assign powerdown_irq_pin_out = 1'b0;
   assign irq = |live_pend;

   // pin taken as power-down only while it is an input
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         power_down <= 1'b0;
      end else if (clk_en) begin
         power_down <= !pin_output_select && !powerdown_irq_pin_in;
      end
   end

   // ==========================================================
   // checks
   sequence s_status_read;
      clk_en && stat_rd && !(|hit_src);
   endsequence

   sequence s_flags_clear;
      pend == FLAGS_RESET;
   endsequence

   sequence s_irq_on;
      pin_output_select && irq_output_enable;
   endsequence

   sequence s_held;
      (|live_pend) && !stat_rd && !ctl_wr && !stat_wr;
   endsequence

   sequence s_ctl_read;
      ctl_rd;
   endsequence

   sequence s_no_read;
      clk_en && !ctl_rd && !stat_rd;
   endsequence

   reset_quiet_a: assert property (
      @(posedge core_clk) $rose(rst_b) |-> !powerdown_irq_pin_oe && src_mask == MASK_RESET)
      else $error("sources not disabled after reset");

   enable_gate_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      !irq_output_enable |-> !powerdown_irq_pin_oe)
      else $error("pin driven with irq output disabled");

   mask_gate_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      clk_en && (|(irq_src & ~src_mask)) && !(|hit_src) && pend == FLAGS_RESET
      |=> pend == FLAGS_RESET)
      else $error("masked source set a flag");

   async_assert_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      pin_output_select && irq_output_enable && (|hit_src)
      |-> powerdown_irq_pin_oe && !powerdown_irq_pin_out)
      else $error("pin not low in the cycle of the condition");

   flag_report_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      clk_en && (|hit_src) |=> (pend & $past(hit_src)) == $past(hit_src))
      else $error("pending flags not all set together");

   read_clear_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      s_status_read |=> s_flags_clear)
      else $error("status read did not clear flags");

   pin_release_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      s_status_read ##1 (s_flags_clear and !(|hit_src)) |-> !powerdown_irq_pin_oe)
      else $error("pin not released after clear");

   mask_write_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      stat_wr |=> src_mask == $past(reg_req.wdata[MASK_LSB +: SRC_N]))
      else $error("mask write not taken");

   pd_input_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      !pin_output_select |-> !powerdown_irq_pin_oe)
      else $error("pin driven while power-down input");

   set_wins_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      stat_rd && (|hit_src) |=> (pend & $past(hit_src)) != FLAGS_RESET)
      else $error("event lost against clearing read");

   read_data_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      stat_rd |=> reg_rdata[FLAG_LSB +: SRC_N] == $past(pend))
      else $error("status read data wrong");

   // ==========================================================
   // checks: reset and register side
   reset_values_a: assert property (
      @(posedge core_clk) $rose(rst_b) |-> pend == FLAGS_RESET && reg_rdata == READ_ZERO
      && pin_output_select == CONTROL_RESET[PIN_OUTPUT_SELECT_BIT]
      && irq_output_enable == CONTROL_RESET[IRQ_OUTPUT_ENABLE_BIT] && !power_down)
      else $error("state not at reset values after reset");

   ctl_write_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      ctl_wr |=> irq_output_enable == $past(reg_req.wdata[IRQ_OUTPUT_ENABLE_BIT])
      && pin_output_select == $past(reg_req.wdata[PIN_OUTPUT_SELECT_BIT]))
      else $error("control write not taken");

   ctl_hold_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      !ctl_wr |=> $stable(irq_output_enable) && $stable(pin_output_select))
      else $error("control bits moved without a write");

   ctl_read_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      s_ctl_read |=> reg_rdata[PIN_OUTPUT_SELECT_BIT] == $past(pin_output_select)
      && reg_rdata[IRQ_OUTPUT_ENABLE_BIT] == $past(irq_output_enable))
      else $error("control read data wrong");

   ctl_upper_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      s_ctl_read |=> reg_rdata[DATA_W-1:IRQ_OUTPUT_ENABLE_BIT+1] == '0)
      else $error("unused control bits read nonzero");

   mask_hold_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      !stat_wr |=> $stable(src_mask))
      else $error("mask moved without a write");

   rdata_idle_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      s_no_read |=> reg_rdata == READ_ZERO)
      else $error("read data stood without a read");

   // clk_en low must leave every flop alone, strobes included
   enable_freeze_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      !clk_en |=> $stable(src_mask) && $stable(pend) && $stable(reg_rdata)
      && $stable(pin_output_select) && $stable(irq_output_enable) && $stable(power_down))
      else $error("state moved while clock enable low");

   // ==========================================================
   // checks: pending flags
   flag_hold_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      !stat_rd |=> (pend & $past(pend)) == $past(pend))
      else $error("flag lost without a status read");

   write_keep_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      stat_wr && !(|hit_src) |=> pend == $past(pend))
      else $error("status write touched the flags");

   multi_flag_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      clk_en && $countones(hit_src) > 1 |=> (pend & $past(hit_src)) == $past(hit_src))
      else $error("simultaneous events not all flagged");

   irq_clear_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      s_status_read |=> !irq)
      else $error("irq stayed high after clearing read");

   // ==========================================================
   // checks: shared pin
   pending_drive_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      s_irq_on ##0 (|live_pend) |-> powerdown_irq_pin_oe)
      else $error("pending flag not driving the pin");

   pin_hold_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      s_irq_on ##0 s_held |=> powerdown_irq_pin_oe)
      else $error("pin released before the status read");

   clear_release_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      s_irq_on ##0 (|live_pend) ##0 s_status_read
      |=> (|hit_src) || !powerdown_irq_pin_oe)
      else $error("pin held after clearing read");

   pin_low_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      powerdown_irq_pin_oe |-> !powerdown_irq_pin_out)
      else $error("pin driven high instead of low");

   powerdown_in_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      clk_en && !pin_output_select && !powerdown_irq_pin_in |=> power_down)
      else $error("low pin not taken as power-down");

   powerdown_off_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      clk_en && pin_output_select |=> !power_down)
      else $error("power-down taken while pin is an output");

endmodule

`default_nettype wire

/* File: sim/pin_partner.sv */
// Purpose: model of the wire and host side of the shared power-down/irq pin
// Assumes: device drive is open-drain, host may pull the pin low
// Notes: a released wire returns to the pull-up level, never to the last value
`default_nettype none

module pin_partner (
   input wire logic oe,
   input wire logic out,
   input wire logic ext_low,
   output logic level
);
   timeunit 1ns;
   timeprecision 1ps;
   // ====
   // wired level
   // weak pull-up loses to any low drive
   assign level = ((oe && !out) || ext_low) ? 1'b0 : 1'b1;
endmodule

`default_nettype wire

/* File: sim/phy_interrupt_logic_tb.sv */
// Purpose: self-checking bench of phy_interrupt_logic
// Assumes: 200 MHz core_clk, read data stands one cycle after the strobe
// Notes: the host side is the bench plus the pin model
`default_nettype none

module phy_interrupt_logic_tb import phy_irq_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b0, ext_low = 1'b0;
   reg_req_s reg_req = '0;
   logic [SRC_N-1:0] irq_src = '0;
   logic [DATA_W-1:0] reg_rdata;
   logic pin, pin_out, pin_oe, power_down, irq;
   int errors = 0;
   int compares = 0;

   initial forever #2.5 core_clk = ~core_clk;

   phy_interrupt_logic u_dut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
      .reg_req(reg_req), .reg_rdata(reg_rdata), .irq_src(irq_src),
      .powerdown_irq_pin_in(pin), .powerdown_irq_pin_out(pin_out),
      .powerdown_irq_pin_oe(pin_oe), .power_down(power_down), .irq(irq));
   pin_partner u_pin (.oe(pin_oe), .out(pin_out), .ext_low(ext_low), .level(pin));

   // ====
   // tasks
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(logic [4:0] a, logic [15:0] d);
      @(posedge core_clk);
      reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      reg_req.wr <= 1'b0;
   endtask

   // read data is looked at in the one cycle where it stands
   task automatic rd(logic [4:0] a, logic [15:0] exp);
      @(posedge core_clk);
      reg_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      reg_req.rd <= 1'b0;
      #1 chk("rdata", exp, reg_rdata);
   endtask

   task automatic ev(logic [7:0] v, logic e_oe, logic e_irq);
      @(posedge core_clk);
      irq_src <= v;
      #1 chk("oe", {15'h0, e_oe}, {15'h0, pin_oe});
      @(posedge core_clk);
      irq_src <= 8'h00;
      #1 chk("irq", {15'h0, e_irq}, {15'h0, irq});
   endtask

   task automatic stop_test();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ====
   // sequence
   initial begin
      #100000;
      errors++;
      stop_test();
   end

   initial begin
      repeat (4) @(posedge core_clk);
      rst_b <= 1'b1;
      clk_en <= 1'b1;
      rd(INTERRUPT_CONTROL_OFFS, 16'h0000);
      rd(INTERRUPT_MASK_AND_STATUS_OFFS, 16'h0000);
      ev(8'h60, 1'b0, 1'b0);
      @(posedge core_clk);
      ext_low <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1 chk("power_down", 16'h0001, {15'h0, power_down});
      @(posedge core_clk);
      ext_low <= 1'b0;
      wr(INTERRUPT_CONTROL_OFFS, 16'h0003);
      rd(INTERRUPT_CONTROL_OFFS, 16'h0003);
      wr(INTERRUPT_MASK_AND_STATUS_OFFS, 16'h0060);
      rd(INTERRUPT_MASK_AND_STATUS_OFFS, 16'h0060);
      @(posedge core_clk);
      ext_low <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1 chk("power_down", 16'h0000, {15'h0, power_down});
      @(posedge core_clk);
      ext_low <= 1'b0;
      ev(8'h60, 1'b1, 1'b1);
      chk("pin", 16'h0000, {15'h0, pin});
      rd(INTERRUPT_MASK_AND_STATUS_OFFS, 16'h6060);
      chk("pin", 16'h0001, {15'h0, pin});
      ev(8'h01, 1'b0, 1'b0);
      rd(INTERRUPT_MASK_AND_STATUS_OFFS, 16'h0060);
      wr(INTERRUPT_CONTROL_OFFS, 16'h0001);
      ev(8'h20, 1'b0, 1'b1);
      rd(INTERRUPT_MASK_AND_STATUS_OFFS, 16'h2060);
      wr(INTERRUPT_CONTROL_OFFS, 16'h0002);
      ev(8'h40, 1'b0, 1'b1);
      rd(INTERRUPT_MASK_AND_STATUS_OFFS, 16'h4060);
      // a flag whose mask is dropped stops the pin and the irq
      wr(INTERRUPT_CONTROL_OFFS, 16'h0003);
      ev(8'h40, 1'b1, 1'b1);
      wr(INTERRUPT_MASK_AND_STATUS_OFFS, 16'h0020);
      #1 chk("irq", 16'h0000, {15'h0, irq});
      chk("oe", 16'h0000, {15'h0, pin_oe});
      wr(INTERRUPT_MASK_AND_STATUS_OFFS, 16'h0060);
      #1 chk("irq", 16'h0001, {15'h0, irq});
      rd(INTERRUPT_MASK_AND_STATUS_OFFS, 16'h4060);
      // a write with clk_en low is ignored
      @(posedge core_clk);
      clk_en <= 1'b0;
      wr(INTERRUPT_MASK_AND_STATUS_OFFS, 16'h00ff);
      clk_en <= 1'b1;
      rd(INTERRUPT_MASK_AND_STATUS_OFFS, 16'h0060);
      // event lands in the very cycle of the clearing read
      @(posedge core_clk);
      reg_req <= '{addr: INTERRUPT_MASK_AND_STATUS_OFFS, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      irq_src <= 8'h20;
      @(posedge core_clk);
      reg_req.rd <= 1'b0;
      irq_src <= 8'h00;
      #1 chk("rdata", 16'h0060, reg_rdata);
      rd(INTERRUPT_MASK_AND_STATUS_OFFS, 16'h2060);
      rd(5'h00, 16'h0000);
      // reset in mid-run with a flag pending
      ev(8'h20, 1'b1, 1'b1);
      @(posedge core_clk);
      rst_b <= 1'b0;
      repeat (4) @(posedge core_clk);
      rst_b <= 1'b1;
      #1 chk("irq", 16'h0000, {15'h0, irq});
      chk("oe", 16'h0000, {15'h0, pin_oe});
      rd(INTERRUPT_CONTROL_OFFS, 16'h0000);
      rd(INTERRUPT_MASK_AND_STATUS_OFFS, 16'h0000);
      stop_test();
   end
endmodule

`default_nettype wire
